// ### logic/swd_diag_consts.svh
// Constants for the switch channel diagnosis block: widths, codes, timing.
// Assumes a 50 MHz system clock; times are in ns, counts derived from them.
`ifndef SWD_DIAG_CONSTS_SVH
`define SWD_DIAG_CONSTS_SVH

`define SWD_NCH 8
`define SWD_SEL_W 4
`define SWD_CNT_W 13
`define SWD_SEL_IDLE 4'hF
`define SWD_SEL_LOOP 4'hA
`define SWD_PASS_DIR 2'h0
`define SWD_PASS_G0 2'h1
`define SWD_PASS_G1 2'h2
`define SWD_NONE_BIT 3

`define SWD_CLK_NS 20
`define SWD_SETTLE_NS 40000
`define SWD_SWITCH_NS 20000
`define SWD_ONWAIT_NS 76000
`define SWD_SYNC_NS 1000

// Longest times: round down to whole cycles
`define SWD_SETTLE_CYC ((`SWD_SETTLE_NS) / (`SWD_CLK_NS))
`define SWD_SWITCH_CYC ((`SWD_SWITCH_NS) / (`SWD_CLK_NS))
`define SWD_ONWAIT_CYC ((`SWD_ONWAIT_NS) / (`SWD_CLK_NS))
`define SWD_SYNC_CYC ((`SWD_SYNC_NS) / (`SWD_CLK_NS))

`endif

// ### logic/swd_pkg.sv
// Types for the switch channel diagnosis block.
// Needs swd_diag_consts.svh for widths.
`include "swd_diag_consts.svh"

package swd_pkg;

	// Analog comparator and protection levels arriving from outside the clock
	typedef struct packed {
		logic [`SWD_NCH-1:0] ovl;
		logic [`SWD_NCH-1:0] ot;
		logic [`SWD_NCH-1:0] above_thr;
		logic on_open_cmp;
	} swd_sense_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SINGLE = 5'h02,
		ST_DIR = 5'h04,
		ST_ARM = 5'h08,
		ST_MEAS = 5'h10
	} swd_state_e_t;

	typedef struct packed {
		swd_sense_t s1;
		swd_sense_t s2;
		swd_sense_t s3;
		swd_sense_t acc;
		logic [`SWD_NCH-1:0] fault;
		logic [`SWD_NCH-1:0] chan_en;
		logic [`SWD_NCH-1:0] pull_en;
		logic [`SWD_NCH-1:0] osm;
		logic off_sum;
		logic [`SWD_SEL_W-1:0] sel;
		swd_state_e_t fsm;
		logic [`SWD_CNT_W-1:0] cnt;
		logic [1:0] pass;
		logic [2:0] ch;
		logic valid;
		logic prev_on;
		logic [`SWD_NCH-1:0] result;
		logic single_sum;
		logic loop_sum;
		logic on_sum;
		logic mux_en;
		logic [2:0] mux_chan;
	} swd_regs_t;

endpackage : swd_pkg

// ### logic/swd_diag.sv
// Diagnosis logic of an eight channel high-side switch: fault latching,
// output level monitor, open-load-in-on checker with select and loop.
// Assumes host strobes are one-cycle pulses on i_clk_sys; analog levels
// in i_sense are asynchronous and are synchronised here.
// Operation
// - Overload/overtemp sets flag, channel off until clear.
// - Channel diagnostics independent except paired channels.
// - Monitor bits refreshed on each monitor read.
// - Per-channel pull current, own enable bit.
// - Open load by monitor only reported, no latch.
// - Off-open summary ORs off, pulled monitor bits.
// - After reset select is 1111, check inactive.
// - Selected channel result valid after settling time.
// - Single select: other bits zero, refresh on read.
// - Single select: summary mirrors result, refresh on read.
// - Select 1010 starts autonomous channel loop.
// - Loop order: direct, generator 0, generator 1.
// - Direct: settle plus sync, then switch plus sync.
// - Direct channel off at its turn gives zero.
// - Generator channel: on edge, wait on-wait plus switch.
// - Generator on phase too short gives zero.
// - Loop end: select 1111, results held.
// - Summary ORs results in loop, holds afterwards.
// - Reserved select values give zero summary.
`timescale 1ns/1ns
`include "swd_diag_consts.svh"

module swd_diag #(
	parameter int unsigned P_PWM_WAIT_CYC = `SWD_ONWAIT_CYC + `SWD_SWITCH_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire swd_pkg::swd_sense_t i_sense,
	input wire logic [`SWD_NCH-1:0] i_chan_on_req,
	input wire logic [`SWD_NCH-1:0] i_latch_clear_bit,
	input wire logic [3:0] i_pair_en,
	input wire logic [`SWD_NCH-1:0] i_pull_current_enable,
	input wire logic [`SWD_NCH-1:0] i_pwm_map0,
	input wire logic [`SWD_NCH-1:0] i_pwm_map1,
	input wire logic i_osm_read,
	input wire logic i_on_open_read,
	input wire logic i_std_diag_read,
	input wire logic i_sel_wr,
	input wire logic [`SWD_SEL_W-1:0] i_sel_data,
	output logic [`SWD_NCH-1:0] o_chan_en,
	output logic [`SWD_NCH-1:0] o_channel_fault_flag,
	output logic [`SWD_NCH-1:0] o_pull_src_en,
	output logic [`SWD_NCH-1:0] o_output_level_monitor,
	output logic o_off_open_summary,
	output logic [`SWD_SEL_W-1:0] o_on_open_select,
	output logic [`SWD_NCH-1:0] o_on_open_result,
	output logic o_on_open_summary,
	output logic o_mux_en,
	output logic [2:0] o_mux_chan
);

	////////////////////////////////////////////////////////////////////////

	// Lowest channel at or above 'from' in mask; bit 3 set when none
	function automatic logic [3:0] swd_next_ch(input logic [`SWD_NCH-1:0] mask,
			input logic [3:0] from);
		logic [3:0] r;
		r = 4'h8;
		for (int i = `SWD_NCH - 1; i >= 0; i--) begin
			if (mask[i] && (4'(i) >= from)) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : swd_next_ch

	// Channels visited in each loop pass; generator 0 wins a double mapping
	function automatic logic [`SWD_NCH-1:0] swd_pass_mask(input logic [1:0] p,
			input logic [`SWD_NCH-1:0] m0, input logic [`SWD_NCH-1:0] m1);
		logic [`SWD_NCH-1:0] r;
		case (p)
			`SWD_PASS_DIR: r = ~(m0 | m1);
			`SWD_PASS_G0: r = m0;
			`SWD_PASS_G1: r = m1 & ~m0;
			default: r = '0;
		endcase
		return r;
	endfunction : swd_pass_mask

	// Select codes 0000 to 0111 name one channel for the single check
	function automatic logic swd_is_chan(input logic [`SWD_SEL_W-1:0] v);
		return v[`SWD_SEL_W-1] == 1'b0;
	endfunction : swd_is_chan

	// Counter step; callers test for zero first, so it never wraps
	function automatic logic [`SWD_CNT_W-1:0] swd_dec(input logic [`SWD_CNT_W-1:0] c);
		return c - `SWD_CNT_W'(1);
	endfunction : swd_dec

	////////////////////////////////////////////////////////////////////////

	localparam logic [`SWD_CNT_W-1:0] C_SET_SYNC =
		`SWD_CNT_W'(`SWD_SETTLE_CYC + `SWD_SYNC_CYC);
	localparam logic [`SWD_CNT_W-1:0] C_SW_SYNC =
		`SWD_CNT_W'(`SWD_SWITCH_CYC + `SWD_SYNC_CYC);
	localparam logic [`SWD_CNT_W-1:0] C_SET = `SWD_CNT_W'(`SWD_SETTLE_CYC);
	localparam logic [`SWD_CNT_W-1:0] C_PWM = `SWD_CNT_W'(P_PWM_WAIT_CYC);

	swd_pkg::swd_regs_t s;
	swd_pkg::swd_regs_t n;

	logic [`SWD_NCH-1:0] evt;
	logic [`SWD_NCH-1:0] pair_evt;
	logic on_now;
	logic cmp;
	logic adv;
	logic scan;
	logic scan_start;
	logic found;
	logic [1:0] p;
	logic [3:0] r;

	always_comb begin
		n = s;
		adv = 1'b0;
		scan = 1'b0;
		scan_start = 1'b0;
		found = 1'b0;
		p = '0;
		r = '0;

		// Three-stage sync; a bit moves only when stages two and three agree
		n.s1 = i_sense;
		n.s2 = s.s1;
		n.s3 = s.s2;
		n.acc = swd_pkg::swd_sense_t'((~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.acc));
		cmp = s.acc.on_open_cmp;

		// Fault latch; a new event beats a clear in the same cycle
		evt = s.acc.ovl | s.acc.ot;
		pair_evt = evt;
		for (int k = 0; k < 4; k++) begin
			if (i_pair_en[k]) begin
				pair_evt[2 * k] = evt[2 * k] | evt[2 * k + 1];
				pair_evt[2 * k + 1] = evt[2 * k] | evt[2 * k + 1];
			end
		end
		n.fault = (s.fault & ~i_latch_clear_bit) | pair_evt;
		n.chan_en = i_chan_on_req & ~n.fault;
		n.pull_en = i_pull_current_enable;

		// Monitor bits touch nothing but reporting
		if (i_osm_read) begin
			n.osm = s.acc.above_thr;
		end
		n.off_sum = |(s.osm & ~s.chan_en & s.pull_en);

		on_now = s.chan_en[s.ch];
		n.prev_on = on_now;

		case (s.fsm)
			swd_pkg::ST_IDLE: begin
				n.mux_en = 1'b0;
			end
			swd_pkg::ST_SINGLE: begin
				// Results read before the settling count ends report zero
				if (s.cnt != '0) begin
					n.cnt = swd_dec(s.cnt);
				end else begin
					n.valid = 1'b1;
				end
				if (i_on_open_read) begin
					n.result = '0;
					n.result[s.ch] = s.valid & cmp;
				end
				if (i_std_diag_read) begin
					n.single_sum = s.valid & cmp;
				end
			end
			swd_pkg::ST_DIR: begin
				if (s.cnt != '0) begin
					n.cnt = swd_dec(s.cnt);
				end else begin
					n.result[s.ch] = on_now & cmp;
					adv = 1'b1;
				end
			end
			swd_pkg::ST_ARM: begin
				if (s.cnt != '0) begin
					n.cnt = swd_dec(s.cnt);
				end else if (on_now && !s.prev_on) begin
					n.fsm = swd_pkg::ST_MEAS;
					n.cnt = C_PWM;
				end
			end
			swd_pkg::ST_MEAS: begin
				// An on phase shorter than the wait cannot be trusted
				if (!on_now) begin
					n.result[s.ch] = 1'b0;
					adv = 1'b1;
				end else if (s.cnt == '0) begin
					n.result[s.ch] = cmp;
					adv = 1'b1;
				end else begin
					n.cnt = swd_dec(s.cnt);
				end
			end
			default: begin
				n.fsm = swd_pkg::ST_IDLE;
			end
		endcase

		// Host write replaces whatever the checker was doing
		if (i_sel_wr) begin
			n.sel = i_sel_data;
			n.valid = 1'b0;
			n.single_sum = 1'b0;
			n.mux_en = 1'b0;
			n.fsm = swd_pkg::ST_IDLE;
			adv = 1'b0;
			if (swd_is_chan(i_sel_data)) begin
				n.fsm = swd_pkg::ST_SINGLE;
				n.ch = i_sel_data[2:0];
				n.cnt = C_SET;
				n.result = '0;
				n.mux_en = 1'b1;
			end else if (i_sel_data == `SWD_SEL_LOOP) begin
				n.result = '0;
				scan = 1'b1;
				scan_start = 1'b1;
			end
		end
		scan = scan | adv;

		// Find the next channel to visit, moving on to later passes
		if (scan) begin
			for (int k = 0; k < 3; k++) begin
				p = scan_start ? 2'(k) : 2'(s.pass + 2'(k));
				if (!found && (p <= `SWD_PASS_G1) && (scan_start || (32'(s.pass) + k <= 2))) begin
					r = swd_next_ch(swd_pass_mask(p, i_pwm_map0, i_pwm_map1),
						(!scan_start && k == 0) ? 4'({1'b0, s.ch} + 4'h1) : 4'h0);
					if (!r[`SWD_NONE_BIT]) begin
						found = 1'b1;
						n.pass = p;
						n.ch = r[2:0];
						n.mux_en = 1'b1;
						if (p == `SWD_PASS_DIR) begin
							n.fsm = swd_pkg::ST_DIR;
							n.cnt = scan_start ? C_SET_SYNC : C_SW_SYNC;
						end else begin
							n.fsm = swd_pkg::ST_ARM;
							// The edge detector still holds the previous channel's level
							n.prev_on = 1'b1;
							// Settling wait only when entering the generator passes
							n.cnt = (scan_start || s.pass == `SWD_PASS_DIR) ? C_SET : '0;
						end
					end
				end
			end
			// Nothing left in any pass: the loop is complete
			if (!found) begin
				n.fsm = swd_pkg::ST_IDLE;
				n.sel = `SWD_SEL_IDLE;
				n.loop_sum = |n.result;
				n.mux_en = 1'b0;
			end
		end
		n.mux_chan = n.ch;

		// Summary as seen by the standard diagnosis word
		case (s.sel)
			`SWD_SEL_LOOP: n.on_sum = |s.result;
			`SWD_SEL_IDLE: n.on_sum = s.loop_sum;
			default: n.on_sum = swd_is_chan(s.sel) ? s.single_sum : 1'b0;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			// Select comes up at 1111, so no open-load-in-on check runs
			s <= '0;
			s.sel <= `SWD_SEL_IDLE;
			s.fsm <= swd_pkg::ST_IDLE;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////

	assign o_chan_en = s.chan_en;
	assign o_channel_fault_flag = s.fault;
	assign o_pull_src_en = s.pull_en;
	assign o_output_level_monitor = s.osm;
	assign o_off_open_summary = s.off_sum;
	assign o_on_open_select = s.sel;
	assign o_on_open_result = s.result;
	assign o_on_open_summary = s.on_sum;
	assign o_mux_en = s.mux_en;
	assign o_mux_chan = s.mux_chan;

endmodule : swd_diag

// ### tb/swd_diag_chk.sv
// Port assertions for the switch channel diagnosis block.
// Bound to swd_diag from the bench top; one clock domain.
`timescale 1ns/1ns
module swd_diag_chk (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic [7:0] i_latch_clear_bit,
	input wire logic [7:0] i_pull_current_enable,
	input wire logic i_osm_read,
	input wire logic i_sel_wr,
	input wire logic [7:0] o_chan_en,
	input wire logic [7:0] o_channel_fault_flag,
	input wire logic [7:0] o_pull_src_en,
	input wire logic [7:0] o_output_level_monitor,
	input wire logic o_off_open_summary,
	input wire logic [3:0] o_on_open_select,
	input wire logic [7:0] o_on_open_result,
	input wire logic o_on_open_summary,
	input wire logic o_mux_en
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	wire logic [3:0] sel = o_on_open_select;
	////////////////////////////////////////////////////////////////
	sequence s_loop_end;
		sel == 4'hA ##1 sel == 4'hF;
	endsequence
	property p_fault_off;
		(o_channel_fault_flag & o_chan_en) == 8'h00;
	endproperty
	property p_fault_hold;
		(|($past(o_channel_fault_flag) & ~o_channel_fault_flag & ~$past(i_latch_clear_bit))) == 1'b0;
	endproperty
	property p_osm_hold;
		!$past(i_osm_read) |-> $stable(o_output_level_monitor);
	endproperty
	property p_pull;
		o_pull_src_en == $past(i_pull_current_enable);
	endproperty
	property p_off_sum;
		o_off_open_summary == |$past(o_output_level_monitor & ~o_chan_en & o_pull_src_en);
	endproperty
	property p_single;
		sel[3] == 1'b0 |-> o_mux_en && (o_on_open_result & ~(8'h01 << sel[2:0])) == 8'h00;
	endproperty
	property p_reserved;
		!(sel inside {[4'h0:4'h7], 4'hA, 4'hF}) |=> !o_on_open_summary;
	endproperty
	property p_loop_sum;
		sel == 4'hA |=> o_on_open_summary == |$past(o_on_open_result);
	endproperty
	property p_hold;
		sel == 4'hF && !i_sel_wr |=> $stable(o_on_open_result);
	endproperty
	property p_loop_end;
		s_loop_end |-> !o_mux_en;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("faulted channel on");
	a_fault_hold: assert property (p_fault_hold) else $error("flag dropped");
	a_osm_hold: assert property (p_osm_hold) else $error("monitor moved");
	a_pull: assert property (p_pull) else $error("pull enable wrong");
	a_off_sum: assert property (p_off_sum) else $error("off summary wrong");
	a_single: assert property (p_single) else $error("single select wrong");
	a_reserved: assert property (p_reserved) else $error("reserved summary");
	a_loop_sum: assert property (p_loop_sum) else $error("loop summary");
	a_hold: assert property (p_hold) else $error("results moved");
	a_loop_end: assert property (p_loop_end) else $error("mux left on");
endmodule : swd_diag_chk

// ### tb/swd_host.sv
// Host model: issues a monitor read strobe after the settling wait.
// Bench raises i_go for one cycle with the channels concerned off.
`timescale 1ns/1ns
module swd_host #(
	parameter int P_WAIT = 1000
) (
	input wire logic i_clk_sys,
	input wire logic i_go,
	output logic o_read = 1'b0
);
	int cnt = 0;
	// Reading early would catch the comparator still settling
	always @(posedge i_clk_sys) begin
		o_read <= cnt == 1;
		if (i_go)
			cnt <= P_WAIT;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
endmodule : swd_host

// ### tb/swd_diag_test.sv
// Self-checking bench for swd_diag: faults, monitor, on-open checks.
// Inputs change at the rising edge; the host model issues monitor reads.
`timescale 1ns/1ns
module swd_diag_test;
	logic i_clk_sys = 1'b0;
	logic i_rst_b = 1'b0;
	swd_pkg::swd_sense_t sense = '0;
	logic [5:0] dir_on = '0;
	logic [1:0] pwm_on = '0;
	logic [7:0] clr = '0, pull = '0, chan_en, fault, pull_en, osm, result;
	logic go = 0, res_rd = 0, std_rd = 0, sel_wr = 0, pwm_run = 0, mux_en;
	logic osm_rd, off_sum, on_sum;
	logic [3:0] pair = '0;
	logic [2:0] mux_chan;
	logic [3:0] sel_d = '0, sel;
	int err_total = 0, compares = 0, t = 0;
	swd_host u_host (.i_clk_sys(i_clk_sys), .i_go(go), .o_read(osm_rd));
	swd_diag #(.P_PWM_WAIT_CYC(20)) dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.i_sense(sense), .i_chan_on_req({pwm_on, dir_on}), .i_latch_clear_bit(clr),
		.i_pair_en(pair), .i_pull_current_enable(pull), .i_pwm_map0(8'h40),
		.i_pwm_map1(8'h80), .i_osm_read(osm_rd), .i_on_open_read(res_rd),
		.i_std_diag_read(std_rd), .i_sel_wr(sel_wr), .i_sel_data(sel_d),
		.o_chan_en(chan_en), .o_channel_fault_flag(fault), .o_pull_src_en(pull_en),
		.o_output_level_monitor(osm), .o_off_open_summary(off_sum),
		.o_on_open_select(sel), .o_on_open_result(result), .o_on_open_summary(on_sum),
		.o_mux_en(mux_en), .o_mux_chan(mux_chan));
	initial forever #10 i_clk_sys = ~i_clk_sys;
	// Channel 7 on phase is shorter than the on-wait, channel 6 long enough
	always @(posedge i_clk_sys) begin
		t <= (t == 99) ? 0 : t + 1;
		pwm_on <= pwm_run ? {t < 8, t < 50} : 2'b00;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask : cyc
	task automatic wr_sel(input logic [3:0] v);
		@(posedge i_clk_sys);
		sel_wr <= 1'b1;
		sel_d <= v;
		@(posedge i_clk_sys);
		sel_wr <= 1'b0;
	endtask : wr_sel
	task automatic rd(input logic [2:0] m);
		@(posedge i_clk_sys);
		{std_rd, res_rd, go} <= m;
		@(posedge i_clk_sys);
		{std_rd, res_rd, go} <= 3'b000;
		cyc(3);
	endtask : rd
	task automatic tally_and_finish();
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	task automatic sc_fault();
		dir_on <= 6'h3F;
		sense.ovl[2] <= 1'b1;
		sense.ot[5] <= 1'b1;
		cyc(8);
		chk(fault, 8'h24);
		chk(chan_en, 8'h1B);
		sense.ovl[2] <= 1'b0;
		sense.ot[5] <= 1'b0;
		cyc(8);
		chk(fault, 8'h24);
		clr <= 8'h24;
		cyc(1);
		clr <= 8'h00;
		cyc(3);
		chk(chan_en, 8'h3F);
		pair <= 4'h2;
		sense.ovl[2] <= 1'b1;
		cyc(8);
		chk(fault, 8'h0C);
		chk(chan_en, 8'h33);
		sense.ovl[2] <= 1'b0;
		cyc(8);
		clr <= 8'h0C;
		cyc(1);
		clr <= 8'h00;
		pair <= 4'h0;
		cyc(3);
		chk(fault, 8'h00);
	endtask : sc_fault
	task automatic sc_osm();
		dir_on <= 6'h30;
		pull <= 8'h0F;
		sense.above_thr <= 8'h35;
		cyc(4);
		rd(3'b001);
		cyc(1005);
		chk(osm, 8'h35);
		chk(pull_en, 8'h0F);
		chk({7'h0, off_sum}, 8'h01);
		sense.above_thr <= 8'h30;
		cyc(8);
		chk(osm, 8'h35);
		rd(3'b001);
		cyc(1005);
		chk(osm, 8'h30);
		chk({7'h0, off_sum}, 8'h00);
		chk(chan_en, 8'h30);
	endtask : sc_osm
	task automatic sc_single();
		dir_on <= 6'h3F;
		sense.on_open_cmp <= 1'b1;
		cyc(100);
		wr_sel(4'h3);
		cyc(2100);
		rd(3'b010);
		chk(result, 8'h08);
		chk({4'h0, mux_en, mux_chan}, 8'h0B);
		rd(3'b100);
		chk({7'h0, on_sum}, 8'h01);
		sense.on_open_cmp <= 1'b0;
		cyc(8);
		rd(3'b010);
		chk(result, 8'h00);
		rd(3'b100);
		chk({7'h0, on_sum}, 8'h00);
	endtask : sc_single
	task automatic sc_loop();
		int n;
		dir_on <= 6'h3D;
		sense.on_open_cmp <= 1'b1;
		pwm_run <= 1'b1;
		wr_sel(4'hA);
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (n < 20000 && sel !== 4'hF);
		if (sel !== 4'hF) begin
			err_total++;
			return;
		end
		chk(result, 8'h7D);
		cyc(3);
		chk({7'h0, on_sum}, 8'h01);
		chk({7'h0, mux_en}, 8'h00);
		wr_sel(4'h9);
		cyc(3);
		chk({7'h0, on_sum}, 8'h00);
		chk(result, 8'h7D);
		wr_sel(4'hA);
		cyc(5);
		wr_sel(4'hF);
		cyc(3000);
		chk(result, 8'h00);
		wr_sel(4'hA);
		cyc(5);
		wr_sel(4'h2);
		cyc(2);
		chk({4'h0, sel}, 8'h02);
		chk({4'h0, mux_en, mux_chan}, 8'h0A);
	endtask : sc_loop
	initial begin
		cyc(8);
		i_rst_b <= 1'b1;
		chk({4'h0, sel}, 8'h0F);
		cyc(2);
		sc_fault();
		sc_osm();
		sc_single();
		sc_loop();
		tally_and_finish();
	end
endmodule : swd_diag_test
bind swd_diag swd_diag_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
	.i_latch_clear_bit(i_latch_clear_bit), .i_pull_current_enable(i_pull_current_enable),
	.i_osm_read(i_osm_read), .i_sel_wr(i_sel_wr), .o_chan_en(o_chan_en),
	.o_channel_fault_flag(o_channel_fault_flag), .o_pull_src_en(o_pull_src_en),
	.o_output_level_monitor(o_output_level_monitor),
	.o_off_open_summary(o_off_open_summary), .o_on_open_select(o_on_open_select),
	.o_on_open_result(o_on_open_result), .o_on_open_summary(o_on_open_summary),
	.o_mux_en(o_mux_en));
